// ---- hw/virl_pkg.sv ----
// Shared constants for the interrupt level router
package virl_pkg;
   localparam int          NUM_LVL     = 7;          // Backplane levels 7..1
   localparam int          ADDR_W      = 6;          // Byte address width
   localparam int          DATA_W      = 32;         // Bus data width
   localparam int          ID_W        = 16;         // Status/ID width
   // Register byte offsets
   localparam logic [5:0]  OFS_IRQ_EN  = 6'h00;      // Set / read interrupt-path mask
   localparam logic [5:0]  OFS_IRQ_DIS = 6'h04;      // Clear interrupt-path mask
   localparam logic [5:0]  OFS_SIG_EN  = 6'h08;      // Set / read signal-path mask
   localparam logic [5:0]  OFS_SIG_DIS = 6'h0c;      // Clear signal-path mask
   localparam logic [5:0]  OFS_ROUTE   = 6'h10;      // Path and width selection
   localparam logic [5:0]  OFS_ACKMODE = 6'h14;      // Release mode per level
   localparam logic [5:0]  OFS_CMDSTAT = 6'h18;      // Status of last command
   localparam logic [5:0]  OFS_PHYS    = 6'h1c;      // Physical enables
   localparam logic [5:0]  OFS_INTSTAT = 6'h20;      // Sticky events, read clears
   localparam logic [5:0]  OFS_INTMASK = 6'h24;      // Event mask
   localparam logic [5:0]  OFS_PEND    = 6'h28;      // Deferred signal enables
   localparam logic [5:0]  OFS_CTLSEL  = 6'h2c;      // Addressed controller
   // Field positions
   localparam int          RT_PATH_LSB = 0;          // Route path bits 6:0
   localparam int          RT_WID_LSB  = 8;          // Route width bits 14:8
   localparam int          PHYS_SIG_LSB = 8;         // Signal enables in PHYS
   localparam int          NUM_EVT     = 3;          // Event count
   localparam int          EVT_IRQ     = 0;          // Id sent to handler path
   localparam int          EVT_SIG     = 1;          // Id sent to signal path
   localparam int          EVT_PEND    = 2;          // Deferred enable applied
   // Command status codes, two's complement
   localparam logic [7:0]  ST_OK       = 8'h00;
   localparam logic [7:0]  ST_QFULL    = 8'h01;
   localparam logic [7:0]  ST_NOHW     = 8'hff;
   localparam logic [7:0]  ST_NOCTL    = 8'hfe;
   // Build options
   localparam logic        HW_SUPPORT  = 1'b1;       // Zero models hardware without support
   localparam logic [7:0]  NUM_CTRL    = 8'h01;      // Controllers present
   localparam logic [7:0]  WIDTH8_MASK = 8'hff;      // Low byte kept for 8-bit ids
   // Bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : virl_pkg

// ---- hw/virl_id_forward.sv ----
// Status/ID steering from an acknowledge cycle to one of two paths
`timescale 1ns/100ps
module virl_id_forward (
   input  wire logic        core_clk,        // System clock
   input  wire logic        rst_b,           // Synchronous reset, active low
   input  wire logic        ack_valid,       // Acknowledge cycle completed
   input  wire logic [2:0]  ack_level,       // Level 1..7
   input  wire logic [15:0] ack_id,          // Fetched status/ID
   input  wire logic        to_signal,       // Route of that level
   input  wire logic        width8,          // Width of that level
   output logic             irq_fwd_valid,   // Pulse to handler path
   output logic [2:0]       irq_fwd_level,
   output logic [15:0]      irq_fwd_id,
   output logic             sig_fwd_valid,   // Pulse to signal path
   output logic [2:0]       sig_fwd_level,
   output logic [15:0]      sig_fwd_id
);
   logic [15:0] id_next;   // Width-trimmed id

   assign id_next = width8 ? (ack_id & {8'h00, virl_pkg::WIDTH8_MASK}) : ack_id;

   // path steering; payload holds until the next cycle on its own path
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq_fwd_valid <= 1'b0;
         irq_fwd_level <= 3'h0;
         irq_fwd_id    <= 16'h0000;
         sig_fwd_valid <= 1'b0;
         sig_fwd_level <= 3'h0;
         sig_fwd_id    <= 16'h0000;
      end else begin
         irq_fwd_valid <= ack_valid & ~to_signal;
         sig_fwd_valid <= ack_valid & to_signal;
         if (ack_valid && !to_signal) begin
            irq_fwd_level <= ack_level;
            irq_fwd_id    <= id_next;
         end
         if (ack_valid && to_signal) begin
            sig_fwd_level <= ack_level;
            sig_fwd_id    <= id_next;
         end
      end
   end
endmodule : virl_id_forward

// ---- hw/virl_top.sv ----
// Interrupt level router: enable masks, routing, release modes, bus slave
//
// Function
// - Enable command sets levels whose bit is one
// - Interrupt path needs enable and route zero
// - Signal path needs signal enable, route one
// - Queue full: status 1, enable after pop
// - Route bits 6:0 pick signal or interrupt
// - Route bits 14:8 pick 8/16-bit id
// - Route change re-evaluates all physical enables
// - Fetched id goes to path per route
// - Ack-mode bit one selects register-access release
// - Register-access release clears enables on acknowledge
// - Status 0 ok, -1 no support, -2 bad controller
// - Disable clears levels whose bit is one
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
module virl_top (
   input  wire logic        core_clk,          // 40 MHz system clock
   input  wire logic        rst_b,             // Synchronous reset, active low
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [5:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   input  wire logic        iack_valid,        // Acknowledge cycle done, one pulse
   input  wire logic [2:0]  iack_level,        // Level acknowledged, 1..7
   input  wire logic [15:0] iack_status_id,    // Status/ID fetched
   input  wire logic        sig_queue_full,    // Signal queue has no room
   input  wire logic        signal_queue_pop,  // One entry removed, pulse
   output logic [6:0]       irq_line_enable,   // Physical interrupt-path enables
   output logic [6:0]       sig_line_enable,   // Physical signal-path enables
   output logic             irq_fwd_valid,
   output logic [2:0]       irq_fwd_level,
   output logic [15:0]      irq_fwd_id,
   output logic             sig_fwd_valid,
   output logic [2:0]       sig_fwd_level,
   output logic [15:0]      sig_fwd_id,
   output logic             irq_out            // Level interrupt to the CPU
);
   // Configuration state
   logic [6:0]  irq_en_reg, irq_en_next;       // Interrupt-path enable mask
   logic [6:0]  sig_en_reg, sig_en_next;       // Signal-path enable mask
   logic [6:0]  pend_reg, pend_next;           // Signal enables waiting for room
   logic [14:0] route_reg, route_next;         // Path and width per level
   logic [6:0]  ackmode_reg, ackmode_next;     // Release mode per level
   logic [7:0]  cmdstat_reg, cmdstat_next;     // Last command status
   logic [7:0]  ctlsel_reg, ctlsel_next;       // Addressed controller
   logic [2:0]  intstat_reg, intstat_next;     // Sticky events
   logic [2:0]  intmask_reg, intmask_next;     // Event mask
   // Bus slave state
   logic        aw_full_reg, w_full_reg;       // Address / data captured
   logic [5:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        ar_take, r_take, aw_take, w_take, b_take;
   logic        wr_fire;                       // Register write happens now
   logic [31:0] lane_mask, wd;                 // Byte-lane filtered data
   logic        wr_irq_en, wr_irq_dis, wr_sig_en, wr_sig_dis;
   logic        wr_route, wr_ackmode, wr_intmask, wr_ctlsel, wr_cmd;
   logic        wr_hit, rd_hit, rd_intstat;
   logic [31:0] rd_mux;
   logic [7:0]  cmd_status;                    // Verdict for a command write
   logic        cmd_ok;                        // Command may act
   logic        sig_defer;                     // Signal enable must wait
   logic        pend_apply;                    // Deferred enable applied now
   logic [6:0]  ack_hit, release_on_register_access_clr;             // Acknowledge decode per level
   logic [6:0]  wr_vec;
   logic [2:0]  evt;                           // Events this cycle
   logic        lvl_route_sig, lvl_width8;     // Settings of acked level
   // Handshakes on the five channels
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take  = s_axi_wvalid & s_axi_wready;
   assign b_take  = s_axi_bvalid & s_axi_bready;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign r_take  = s_axi_rvalid & s_axi_rready;
   // Write executes once both halves are held and no response is pending
   assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   // Byte lanes with a low strobe read as zero, so set/clear leaves them alone
   assign lane_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign wd        = w_data_reg & lane_mask;
   assign wr_vec    = wd[6:0];
   // Write address decode
   assign wr_irq_en  = wr_fire & (aw_addr_reg == virl_pkg::OFS_IRQ_EN);
   assign wr_irq_dis = wr_fire & (aw_addr_reg == virl_pkg::OFS_IRQ_DIS);
   assign wr_sig_en  = wr_fire & (aw_addr_reg == virl_pkg::OFS_SIG_EN);
   assign wr_sig_dis = wr_fire & (aw_addr_reg == virl_pkg::OFS_SIG_DIS);
   assign wr_route   = wr_fire & (aw_addr_reg == virl_pkg::OFS_ROUTE);
   assign wr_ackmode = wr_fire & (aw_addr_reg == virl_pkg::OFS_ACKMODE);
   assign wr_intmask = wr_fire & (aw_addr_reg == virl_pkg::OFS_INTMASK);
   assign wr_ctlsel  = wr_fire & (aw_addr_reg == virl_pkg::OFS_CTLSEL);
   assign wr_cmd     = wr_irq_en | wr_irq_dis | wr_sig_en | wr_sig_dis
                       | wr_route | wr_ackmode;
   // Read-only registers accept writes silently
   assign wr_hit = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= virl_pkg::OFS_CTLSEL);
   // command verdict, missing hardware checked first
   assign cmd_status = !virl_pkg::HW_SUPPORT           ? virl_pkg::ST_NOHW  :
                       (ctlsel_reg >= virl_pkg::NUM_CTRL) ? virl_pkg::ST_NOCTL :
                       sig_defer                         ? virl_pkg::ST_QFULL :
                                                           virl_pkg::ST_OK;
   assign cmd_ok = virl_pkg::HW_SUPPORT & (ctlsel_reg < virl_pkg::NUM_CTRL);
   // a full queue defers a signal enable
   assign sig_defer  = wr_sig_en & sig_queue_full & (wr_vec != 7'h00);
   assign pend_apply = signal_queue_pop & (pend_reg != 7'h00);
   // Acknowledge decode and release handling, one slice per level
   genvar g;
   generate
      for (g = 0; g < virl_pkg::NUM_LVL; g++) begin : g_lvl
         assign ack_hit[g]  = iack_valid & (iack_level == 3'(g + 1));
         assign release_on_register_access_clr[g] = ack_hit[g] & ackmode_reg[g];
      end
   endgenerate
   // Next values of the enable masks; a new enable beats a release clear
   always_comb begin
      irq_en_next = irq_en_reg & ~release_on_register_access_clr;
      sig_en_next = sig_en_reg & ~release_on_register_access_clr;
      pend_next   = pend_reg;
      if (pend_apply) begin
         // deferred enable lands after a pop
         sig_en_next = sig_en_next | pend_reg;
         pend_next   = 7'h00;
      end
      if (cmd_ok) begin
         if (wr_irq_en)
            irq_en_next = irq_en_next | wr_vec;
         if (wr_irq_dis)
            irq_en_next = irq_en_next & ~wr_vec;
         if (wr_sig_en && sig_defer)
            pend_next = pend_next | wr_vec;
         else if (wr_sig_en)
            sig_en_next = sig_en_next | wr_vec;
         if (wr_sig_dis) begin
            sig_en_next = sig_en_next & ~wr_vec;
            pend_next   = pend_next & ~wr_vec;
         end
      end
   end
   // route and ack mode honour byte strobes
   assign route_next   = (wr_route && cmd_ok) ?
                         ((route_reg & ~lane_mask[14:0]) | wd[14:0]) : route_reg;
   assign ackmode_next = (wr_ackmode && cmd_ok) ?
                         ((ackmode_reg & ~lane_mask[6:0]) | wr_vec) : ackmode_reg;
   assign cmdstat_next = wr_cmd ? cmd_status : cmdstat_reg;
   assign ctlsel_next  = wr_ctlsel ?
                         ((ctlsel_reg & ~lane_mask[7:0]) | wd[7:0]) : ctlsel_reg;
   assign intmask_next = wr_intmask ?
                         ((intmask_reg & ~lane_mask[2:0]) | wd[2:0]) : intmask_reg;
   // Events; a read clears the sticky bits but an event that cycle survives
   assign evt[virl_pkg::EVT_IRQ]  = iack_valid & ~lvl_route_sig;
   assign evt[virl_pkg::EVT_SIG]  = iack_valid & lvl_route_sig;
   assign evt[virl_pkg::EVT_PEND] = pend_apply;
   assign rd_intstat   = ar_take & (s_axi_araddr == virl_pkg::OFS_INTSTAT);
   assign intstat_next = (rd_intstat ? 3'h0 : intstat_reg) | evt;
   // Settings of the level being acknowledged
   assign lvl_route_sig = |(ack_hit & route_reg[6:0]);
   assign lvl_width8    = |(ack_hit & route_reg[14:8]);
   // Read data selection
   assign rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= virl_pkg::OFS_CTLSEL);
   assign rd_mux =
      (s_axi_araddr == virl_pkg::OFS_IRQ_EN)  ? {25'h0, irq_en_reg} :
      (s_axi_araddr == virl_pkg::OFS_SIG_EN)  ? {25'h0, sig_en_reg} :
      (s_axi_araddr == virl_pkg::OFS_ROUTE)   ? {17'h0, route_reg} :
      (s_axi_araddr == virl_pkg::OFS_ACKMODE) ? {25'h0, ackmode_reg} :
      (s_axi_araddr == virl_pkg::OFS_CMDSTAT) ? {{24{cmdstat_reg[7]}}, cmdstat_reg} :
      (s_axi_araddr == virl_pkg::OFS_PHYS)    ? {17'h0, sig_line_enable, 1'b0,
                                                 irq_line_enable} :
      (s_axi_araddr == virl_pkg::OFS_INTSTAT) ? {29'h0, intstat_reg} :
      (s_axi_araddr == virl_pkg::OFS_INTMASK) ? {29'h0, intmask_reg} :
      (s_axi_araddr == virl_pkg::OFS_PEND)    ? {25'h0, pend_reg} :
      (s_axi_araddr == virl_pkg::OFS_CTLSEL)  ? {24'h0, ctlsel_reg} :
                                                32'h0;
   // Write channel capture and response
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         aw_addr_reg   <= 6'h00;
         w_data_reg    <= 32'h0;
         w_strb_reg    <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= virl_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
         end
         if (wr_fire) begin
            // Unmapped or misaligned address answers SLVERR
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? virl_pkg::RESP_OKAY : virl_pkg::RESP_SLVERR;
         end
         // Ready returns only after the response, one write at a time
         if (b_take) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end
   // Read channel; data register loads when the address is taken
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= virl_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? virl_pkg::RESP_OKAY : virl_pkg::RESP_SLVERR;
      end else if (r_take) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end
   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         // reset to all disabled, interrupt path, 16-bit, ack release
         irq_en_reg  <= 7'h00;
         sig_en_reg  <= 7'h00;
         pend_reg    <= 7'h00;
         route_reg   <= 15'h0000;
         ackmode_reg <= 7'h00;
         cmdstat_reg <= virl_pkg::ST_OK;
         ctlsel_reg  <= 8'h00;
         intstat_reg <= 3'h0;
         intmask_reg <= 3'h0;
      end else begin
         irq_en_reg  <= irq_en_next;
         sig_en_reg  <= sig_en_next;
         pend_reg    <= pend_next;
         route_reg   <= route_next;
         ackmode_reg <= ackmode_next;
         cmdstat_reg <= cmdstat_next;
         ctlsel_reg  <= ctlsel_next;
         intstat_reg <= intstat_next;
         intmask_reg <= intmask_next;
      end
   end
   // Physical enables follow the stored state one cycle later, from flops
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         irq_line_enable <= 7'h00;
         sig_line_enable <= 7'h00;
         irq_out         <= 1'b0;
      end else begin
         irq_line_enable <= irq_en_reg & ~route_reg[6:0];
         sig_line_enable <= sig_en_reg & route_reg[6:0];
         irq_out         <= |(intstat_next & intmask_next);
      end
   end
   virl_id_forward u_fwd (
      .core_clk      (core_clk),
      .rst_b         (rst_b),
      .ack_valid     (iack_valid),
      .ack_level     (iack_level),
      .ack_id        (iack_status_id),
      .to_signal     (lvl_route_sig),
      .width8        (lvl_width8),
      .irq_fwd_valid (irq_fwd_valid),
      .irq_fwd_level (irq_fwd_level),
      .irq_fwd_id    (irq_fwd_id),
      .sig_fwd_valid (sig_fwd_valid),
      .sig_fwd_level (sig_fwd_level),
      .sig_fwd_id    (sig_fwd_id)
   );
   // Checks beside the logic
   property p_irq_phys;
      @(posedge core_clk) disable iff (!rst_b)
      1'b1 |=> irq_line_enable == $past(irq_en_reg & ~route_reg[6:0]);
   endproperty
   a_irq_phys: assert property (p_irq_phys) else $error("irq line enable wrong");
   property p_sig_phys;
      @(posedge core_clk) disable iff (!rst_b)
      1'b1 |=> sig_line_enable == $past(sig_en_reg & route_reg[6:0]);
   endproperty
   a_sig_phys: assert property (p_sig_phys) else $error("signal line enable wrong");
   property p_set_only;
      @(posedge core_clk) disable iff (!rst_b)
      (wr_irq_en && cmd_ok) |=> ((irq_en_reg & $past(wr_vec)) == $past(wr_vec))
                                && ((irq_en_reg | $past(irq_en_reg & ~release_on_register_access_clr))
                                    == irq_en_reg);
   endproperty
   a_set_only: assert property (p_set_only) else $error("enable command lost a bit");
   property p_clear_only;
      @(posedge core_clk) disable iff (!rst_b)
      (wr_irq_dis && cmd_ok) |=> (irq_en_reg & $past(wr_vec)) == 7'h00
                                 && irq_en_reg == ($past(irq_en_reg) & ~$past(wr_vec)
                                                   & ~$past(release_on_register_access_clr));
   endproperty
   a_clear_only: assert property (p_clear_only) else $error("disable command wrong");
   property p_defer;
      @(posedge core_clk) disable iff (!rst_b)
      (sig_defer && cmd_ok && !pend_apply) |=> cmdstat_reg == virl_pkg::ST_QFULL
                                              && (pend_reg & $past(wr_vec)) == $past(wr_vec);
   endproperty
   a_defer: assert property (p_defer) else $error("queue full not deferred");
   property p_route_reeval;
      @(posedge core_clk) disable iff (!rst_b)
      $changed(route_reg) |=> irq_line_enable == $past(irq_en_reg & ~route_reg[6:0])
                              && sig_line_enable == $past(sig_en_reg & route_reg[6:0]);
   endproperty
   a_route_reeval: assert property (p_route_reeval) else $error("route not applied");
   property p_release_on_register_access_clear;
      @(posedge core_clk) disable iff (!rst_b)
      (|release_on_register_access_clr && !wr_fire && !pend_apply) |=>
         ((irq_en_reg | sig_en_reg) & $past(release_on_register_access_clr)) == 7'h00;
   endproperty
   a_release_on_register_access_clear: assert property (p_release_on_register_access_clear) else $error("release did not clear");
   property p_bad_ctl;
      @(posedge core_clk) disable iff (!rst_b)
      (wr_cmd && virl_pkg::HW_SUPPORT && ctlsel_reg >= virl_pkg::NUM_CTRL)
         |=> cmdstat_reg == virl_pkg::ST_NOCTL && $stable(route_reg);
   endproperty
   a_bad_ctl: assert property (p_bad_ctl) else $error("bad controller accepted");
   property p_steer;
      @(posedge core_clk) disable iff (!rst_b)
      iack_valid |=> (sig_fwd_valid == $past(lvl_route_sig))
                     && (irq_fwd_valid != sig_fwd_valid);
   endproperty
   a_steer: assert property (p_steer) else $error("id sent to wrong path");
   property p_width8;
      @(posedge core_clk) disable iff (!rst_b)
      (iack_valid && lvl_width8) |=> (irq_fwd_valid ? irq_fwd_id[15:8] : sig_fwd_id[15:8])
                                     == 8'h00;
   endproperty
   a_width8: assert property (p_width8) else $error("8-bit id not trimmed");
   c_defer_then_pop: cover property (@(posedge core_clk) disable iff (!rst_b)
                                     sig_defer ##[1:20] pend_apply);
   c_release_on_register_access_ack: cover property (@(posedge core_clk) disable iff (!rst_b) |release_on_register_access_clr);
   c_sig_fwd: cover property (@(posedge core_clk) disable iff (!rst_b) sig_fwd_valid);
   c_irq_out: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(irq_out));
endmodule : virl_top

// ---- tb/virl_far_model.sv ----
// Behavioural backplane interrupter answering acknowledge cycles
`timescale 1ns/100ps
module virl_far_model (
   input  wire logic        core_clk,       // System clock
   input  wire logic        rst_b,          // Synchronous reset, active low
   input  wire logic        ack_go,         // Bench asks for one acknowledge cycle
   input  wire logic [2:0]  ack_lvl,        // Level being acknowledged
   input  wire logic [15:0] ack_val,        // Id the interrupter hands back
   output logic             iack_valid,     // One-cycle completion pulse
   output logic [2:0]       iack_level,
   output logic [15:0]      iack_status_id
);
   // Released id bus toggles so a stale id is never mistaken for a fresh one
   always_ff @(posedge core_clk) begin
      iack_valid     <= rst_b & ack_go;
      iack_level     <= ack_lvl;
      iack_status_id <= rst_b ? (ack_go ? ack_val : ~iack_status_id) : 16'ha5c3;
   end
endmodule : virl_far_model

// ---- tb/virl_tb.sv ----
// Self-checking bench for the interrupt level router
`timescale 1ns/100ps
module vxi_irq_level_router_tb_top;
   logic core_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, iack_valid;
   logic sig_queue_full, signal_queue_pop, irq_fwd_valid, sig_fwd_valid, irq_out, ack_go;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [5:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  iack_level, irq_fwd_level, sig_fwd_level, ack_lvl;
   logic [15:0] iack_status_id, irq_fwd_id, sig_fwd_id, ack_val;
   logic [6:0]  irq_line_enable, sig_line_enable, mi, ms, rt, dd;
   int          errors, n_tests;
   virl_top dut (.*);
   virl_far_model far (.*);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, ex, got);
      end
   endtask : chk
   // Bus write: address and data offered together, each released when taken
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {3'h7, a, d};
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid === 1'b1));
      s_axi_bready <= 1'b0;
   endtask : wr
   // Bus read: data and response taken at the rvalid edge
   task automatic rdr(input logic [5:0] a);
      @(posedge core_clk);
      {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid === 1'b1));
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
   endtask : rdr
   // Expected physical enables: masks gated by route
   function automatic logic [31:0] phys(input logic [6:0] i, s, r);
      return {17'h0, s & r, 1'b0, i & ~r};
   endfunction : phys
   task automatic end_sim;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      end_sim();
   end
   initial begin
      {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ack_go, ack_lvl, ack_val} = '0;
      {sig_queue_full, signal_queue_pop, mi, ms, rt, dd} = '0;
      s_axi_wstrb = 4'hf;
      rd = $urandom(32'h3e51);
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         rdr(6'(k * 4));
         chk("reset value", 32'h0, rd);
      end
      // Random enables, disables and routes
      repeat (6) begin
         rd = $urandom;
         {rt, dd} = rd[27:14];
         mi = (mi | rd[6:0]) & ~dd;
         ms = ms | rd[13:7];
         wr(virl_pkg::OFS_IRQ_EN, 32'(rd[6:0]));
         wr(virl_pkg::OFS_SIG_EN, 32'(rd[13:7]));
         wr(virl_pkg::OFS_IRQ_DIS, 32'(dd));
         wr(virl_pkg::OFS_ROUTE, 32'(rt));
         rdr(virl_pkg::OFS_PHYS);
         chk("phys", phys(mi, ms, rt), rd);
         chk("lines", phys(mi, ms, rt), {17'h0, sig_line_enable, 1'b0, irq_line_enable});
         rdr(virl_pkg::OFS_IRQ_EN);
         chk("irq mask", 32'(mi), rd);
         rdr(virl_pkg::OFS_CMDSTAT);
         chk("status ok", 32'h0, rd);
      end
      // Signal enable held back while the queue is full
      wr(virl_pkg::OFS_SIG_DIS, 32'h7f);
      sig_queue_full <= 1'b1;
      wr(virl_pkg::OFS_SIG_EN, 32'h4);
      rdr(virl_pkg::OFS_CMDSTAT);
      chk("queue full", 32'h1, rd);
      signal_queue_pop <= 1'b1;
      @(posedge core_clk);
      {sig_queue_full, signal_queue_pop} <= 2'h0;
      rdr(virl_pkg::OFS_SIG_EN);
      chk("after pop", 32'h4, rd);
      wr(virl_pkg::OFS_CTLSEL, 32'h1);
      wr(virl_pkg::OFS_ROUTE, 32'h7f);
      rdr(virl_pkg::OFS_CMDSTAT);
      chk("bad ctl", 32'hfffffffe, rd);
      rdr(virl_pkg::OFS_ROUTE);
      chk("route kept", 32'(rt), rd);
      wr(virl_pkg::OFS_CTLSEL, 32'h0);
      rdr(6'h3c);
      chk("unmapped", 32'(virl_pkg::RESP_SLVERR), 32'(rr));
      // Low four levels to signal path, odd levels 8-bit, level 2 releases
      {rt, dd} = {7'h0f, 7'h55};
      wr(virl_pkg::OFS_IRQ_EN, 32'h7f);
      wr(virl_pkg::OFS_SIG_EN, 32'h7f);
      wr(virl_pkg::OFS_ROUTE, 32'({dd, 1'b0, rt}));
      wr(virl_pkg::OFS_ACKMODE, 32'h2);
      for (int l = 1; l < 8; l++) begin
         @(posedge core_clk);
         {ack_go, ack_lvl, ack_val} <= {1'b1, 3'(l), 16'($urandom)};
         @(posedge core_clk);
         ack_go <= 1'b0;
         @(posedge core_clk);
         @(negedge core_clk);
         chk("fwd valid", 32'({rt[l-1], ~rt[l-1]}), 32'({sig_fwd_valid, irq_fwd_valid}));
         chk("fwd", {13'h0, 3'(l), ack_val & {~{8{dd[l-1]}}, 8'hff}}, rt[l-1] ? {13'h0,
            sig_fwd_level, sig_fwd_id} : {13'h0, irq_fwd_level, irq_fwd_id});
      end
      chk("masked irq", 32'h0, 32'(irq_out));
      wr(virl_pkg::OFS_INTMASK, 32'h3);
      chk("raised irq", 32'h1, 32'(irq_out));
      rdr(virl_pkg::OFS_INTSTAT);
      chk("events", 32'h7, rd);
      @(posedge core_clk);
      chk("cleared irq", 32'h0, 32'(irq_out));
      rdr(virl_pkg::OFS_IRQ_EN);
      chk("released", 32'h7d, rd);
      wr(virl_pkg::OFS_IRQ_EN, 32'h2);
      rdr(virl_pkg::OFS_IRQ_EN);
      chk("re-enabled", 32'h7f, rd);
      end_sim();
   end
endmodule : vxi_irq_level_router_tb_top
